// ==== acd_audio_decoder.sv ====
// Behaviour
// - data steady while clock high
// - detect start and stop conditions
// - eight bits MSB first, then ack
// - device pulls data low ninth pulse
// - master releases data during ack
// - master may stop on missing ack
// - master may ignore ack slot
// - start, address, data bytes, stop
// - answer only write address 10001000
// - prefix 00 sets volume
// - prefix 1xx sets speaker attenuators, mute
// - prefix 010 sets source, loudness, gain
// - source code four is internal source
// - prefix 0110 bass, 0111 treble
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`include "acd_defs.svh"
module acd_audio_decoder (
    input  wire logic                  clk,
    input  wire logic                  srst,
    acd_bus_if.device                  bus,
    output logic [2:0]                 coarseStepVol_q,
    output logic [2:0]                 fineStepVol_q,
    output logic [4:0]                 attLf_q,
    output logic [4:0]                 attRf_q,
    output logic [4:0]                 attLr_q,
    output logic [4:0]                 attRr_q,
    output logic [3:0]                 muteMask_q,
    output logic [1:0]                 sourceSelect_q,
    output logic                       internalFourthSource_q,
    output logic                       loudnessOff_q,
    output logic [1:0]                 inputGainField_q,
    output logic [3:0]                 lowTone_q,
    output logic [3:0]                 highTone_q,
    output logic                       settingStrobe_q
);
    import acd_pkg::*;

    typedef struct packed {
        logic [1:0]          sclSync;
        logic [1:0]          sdaSync;
        logic                sclPrev;
        logic                sdaPrev;
        acd_slave_state_type state;
        logic [3:0]          bitCnt;
        logic [7:0]          shift;
        logic                isAddr;
        logic                ackOn;
        logic                selected;
        logic                strobe;
        acd_settings_type    set;
        logic [3:0]          mute;
        logic                fourth;
    } acd_dev_state_type;

    acd_dev_state_type s_q;
    acd_dev_state_type s_d;

    logic sclNow;
    logic sdaNow;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic [7:0] rxByte;

    // apply one data byte to the setting it addresses
    function automatic acd_settings_type applyByte(
        input acd_settings_type cur,
        input logic [7:0]       b
    );
        acd_settings_type n;
        n = cur;
        if (b[`ACD_VOL_PFX_POS] == `ACD_VOL_PFX) begin
            n.volume = b;
        end else if (b[`ACD_SPK_PFX_POS]) begin
            case (b[`ACD_SPK_SEL_POS])
                `ACD_SPK_LF: n.attLf = b;
                `ACD_SPK_RF: n.attRf = b;
                `ACD_SPK_LR: n.attLr = b;
                default:     n.attRr = b;
            endcase
        end else if (b[`ACD_SW_PFX_POS] == `ACD_SW_PFX) begin
            n.switchSet = b;
        end else if (b[`ACD_TONE_PFX_POS] == `ACD_BASS_PFX) begin
            n.lowTone = b;
        end else begin
            n.highTone = b;
        end
        return n;
    endfunction : applyByte

    assign sclNow  = s_q.sclSync[1];
    assign sdaNow  = s_q.sdaSync[1];
    assign sclRise = sclNow && !s_q.sclPrev;
    assign sclFall = !sclNow && s_q.sclPrev;
    assign startSeen = sclNow && s_q.sclPrev && s_q.sdaPrev && !sdaNow;
    assign stopSeen  = sclNow && s_q.sclPrev && !s_q.sdaPrev && sdaNow;
    assign rxByte    = {s_q.shift[6:0], sdaNow};

    always_comb begin
        s_d = s_q;
        s_d.sclSync = {s_q.sclSync[0], bus.scl};
        s_d.sdaSync = {s_q.sdaSync[0], bus.sda};
        s_d.sclPrev = sclNow;
        s_d.sdaPrev = sdaNow;
        s_d.strobe  = 1'b0;
        if (startSeen) begin
            s_d.state    = ACD_S_BITS;
            s_d.bitCnt   = 4'h0;
            s_d.isAddr   = 1'b1;
            s_d.selected = 1'b0;
            s_d.ackOn    = 1'b0;
        end else if (stopSeen) begin
            s_d.state    = ACD_S_IDLE;
            s_d.ackOn    = 1'b0;
            s_d.selected = 1'b0;
        end else begin
            case (s_q.state)
                ACD_S_IDLE: begin
                    s_d.ackOn = 1'b0;
                end
                ACD_S_BITS: begin
                    if (sclRise) begin
                        s_d.shift  = rxByte;
                        s_d.bitCnt = s_q.bitCnt + 4'h1;
                    end
                    if (sclFall && s_q.bitCnt == `ACD_BYTE_BITS) begin
                        s_d.bitCnt = 4'h0;
                        if (s_q.isAddr) begin
                            if (s_q.shift == `ACD_CHIP_ADDR) begin
                                s_d.selected = 1'b1;
                                s_d.ackOn    = 1'b1;
                                s_d.state    = ACD_S_ACK;
                            end else begin
                                s_d.state = ACD_S_SKIP;
                            end
                        end else begin
                            s_d.ackOn = 1'b1;
                            s_d.state = ACD_S_ACK;
                            s_d.set   = applyByte(s_q.set, s_q.shift);
                            s_d.strobe = 1'b1;
                        end
                        s_d.isAddr = 1'b0;
                    end
                end
                ACD_S_ACK: begin
                    if (sclFall) begin
                        s_d.ackOn = 1'b0;
                        s_d.state = ACD_S_BITS;
                    end
                end
                ACD_S_SKIP: begin
                    s_d.ackOn = 1'b0;
                end
                default: begin
                    s_d.state = ACD_S_IDLE;
                end
            endcase
        end
        // all five low bits set mutes
        s_d.mute   = {s_d.set.attRr[4:0] == `ACD_MUTE_CODE,
                      s_d.set.attLr[4:0] == `ACD_MUTE_CODE,
                      s_d.set.attRf[4:0] == `ACD_MUTE_CODE,
                      s_d.set.attLf[4:0] == `ACD_MUTE_CODE};
        s_d.fourth = &s_d.set.switchSet[1:0];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q.sclSync  <= 2'h3;
            s_q.sdaSync  <= 2'h3;
            s_q.sclPrev  <= 1'b1;
            s_q.sdaPrev  <= 1'b1;
            s_q.state    <= ACD_S_IDLE;
            s_q.bitCnt   <= 4'h0;
            s_q.shift    <= 8'h00;
            s_q.isAddr   <= 1'b0;
            s_q.ackOn    <= 1'b0;
            s_q.selected <= 1'b0;
            s_q.strobe   <= 1'b0;
            // settings kept across reset would be undefined; zero instead
            s_q.set      <= '0;
            s_q.mute     <= 4'h0;
            s_q.fourth   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // drive only low, only during ack
    assign bus.sdaDevOut = 1'b0;
    assign bus.sdaDevOe  = s_q.ackOn;

    assign coarseStepVol_q = s_q.set.volume[5:3];
    assign fineStepVol_q   = s_q.set.volume[2:0];
    assign attLf_q         = s_q.set.attLf[4:0];
    assign attRf_q         = s_q.set.attRf[4:0];
    assign attLr_q         = s_q.set.attLr[4:0];
    assign attRr_q         = s_q.set.attRr[4:0];
    assign muteMask_q      = s_q.mute;
    assign sourceSelect_q  = s_q.set.switchSet[1:0];
    assign internalFourthSource_q = s_q.fourth;
    assign loudnessOff_q    = s_q.set.switchSet[2];
    assign inputGainField_q = s_q.set.switchSet[4:3];
    assign lowTone_q        = s_q.set.lowTone[3:0];
    assign highTone_q       = s_q.set.highTone[3:0];
    assign settingStrobe_q  = s_q.strobe;
endmodule : acd_audio_decoder

// ==== acd_bus_asserts.sv ====
`timescale 1ns/10ps
`include "acd_defs.svh"
module acd_bus_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sdaMstOe,
    input wire logic sdaDevOe,
    input wire logic sdaDevOut
);
    logic       sclPrev_q;
    logic       sdaPrev_q;
    logic       first_q;
    logic       addrOk_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic       startSeen;
    logic       stopSeen;
    logic       sclRise;

    assign startSeen = scl && sclPrev_q && sdaPrev_q && !sda;
    assign stopSeen  = scl && sclPrev_q && !sdaPrev_q && sda;
    assign sclRise   = scl && !sclPrev_q;

    // slot 0..7 data bits, slot 8 the ack pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            first_q   <= 1'b0;
            addrOk_q  <= 1'b0;
            bitCnt_q  <= 4'h0;
            shift_q   <= 8'h00;
        end else begin
            sclPrev_q <= scl;
            sdaPrev_q <= sda;
            if (startSeen || stopSeen) begin
                bitCnt_q <= 4'h0;
                first_q  <= startSeen;
                addrOk_q <= 1'b0;
            end else if (sclRise && bitCnt_q == 4'h8) begin
                bitCnt_q <= 4'h0;
                first_q  <= 1'b0;
                addrOk_q <= first_q ? shift_q == `ACD_CHIP_ADDR : addrOk_q;
            end else if (sclRise) begin
                bitCnt_q <= bitCnt_q + 4'h1;
                shift_q  <= {shift_q[6:0], sda};
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    dev_data_stable_a: assert property (
        scl && sclPrev_q |-> $stable(sdaDevOe))
        else $error("device sda moved while scl high");
    mst_data_stable_a: assert property (
        scl && sclPrev_q && !$stable(sdaMstOe) |-> startSeen || stopSeen)
        else $error("master sda moved inside a byte with scl high");
    start_clock_a: assert property (
        startSeen |-> ##[1:24] !scl)
        else $error("no clocking after start");
    stop_idle_a: assert property (
        stopSeen |-> scl [*8])
        else $error("scl not idle after stop");
    ack_slot_a: assert property (
        sclRise && sdaDevOe |-> bitCnt_q == 4'h8)
        else $error("device pulled sda outside the ninth pulse");
    ack_held_a: assert property (
        $rose(sdaDevOe) |-> ##[1:12] sclRise ##0 (scl && sdaDevOe) [*8])
        else $error("ack not held over the whole pulse");
    mst_release_a: assert property (
        sclRise && bitCnt_q == 4'h8 |-> !sdaMstOe)
        else $error("master drives sda in ack slot");
    addr_match_a: assert property (
        sclRise && bitCnt_q == 4'h8 |->
        sdaDevOe == (first_q ? shift_q == `ACD_CHIP_ADDR : addrOk_q))
        else $error("ack does not follow address match");
    dev_low_only_a: assert property (
        sdaDevOe |-> !sdaDevOut && (first_q || addrOk_q) &&
        (bitCnt_q == 4'h8 || bitCnt_q == 4'h0))
        else $error("device drives sda outside its ack");
endmodule : acd_bus_asserts

// ==== acd_bus_if.sv ====
`timescale 1ns/10ps
interface acd_bus_if;
    logic sclOut;
    logic sclOe;
    logic sdaMstOut;
    logic sdaMstOe;
    logic sdaDevOut;
    logic sdaDevOe;
    wire  scl;
    wire  sda;
    // open drain with pull-up: any enabled low driver wins
    assign scl = !(sclOe && !sclOut);
    assign sda = !((sdaMstOe && !sdaMstOut) || (sdaDevOe && !sdaDevOut));

    modport master (
        output sclOut, sclOe, sdaMstOut, sdaMstOe,
        input  scl, sda
    );
    modport device (
        output sdaDevOut, sdaDevOe,
        input  scl, sda
    );
endinterface : acd_bus_if

// ==== acd_bus_master.sv ====
`timescale 1ns/10ps
`include "acd_defs.svh"
module acd_bus_master #(
    parameter logic [7:0] HALF_DIV = `ACD_LINK_DIV
) (
    input  wire logic                  clk,
    input  wire logic                  srst,
    acd_bus_if.master                  bus,
    input  wire logic [3:0]            cmdAddr,
    input  wire logic [7:0]            cmdWrData,
    input  wire logic                  cmdWrite,
    input  wire logic                  cmdRead,
    output logic [7:0]                 cmdRdData
);
    import acd_pkg::*;

    // ctrl: bit0 go (pulse), bit1 stop after byte, bit2 skip ack check
    typedef struct packed {
        acd_master_state_type state;
        logic [7:0]           div;
        logic                 phase;
        logic [3:0]           bitCnt;
        logic [7:0]           shift;
        logic [7:0]           addrByte;
        logic [7:0]           dataByte;
        logic                 haveData;
        logic                 stopAfter;
        logic                 ignoreAck;
        logic                 nack;
        logic                 busy;
        logic                 sclDrv;
        logic                 sdaDrv;
        logic [1:0]           sdaSync;
        logic [7:0]           rd;
    } acd_mst_state_type;

    acd_mst_state_type s_q;
    acd_mst_state_type s_d;
    logic tick;
    logic dataWr;

    assign tick   = (s_q.div == HALF_DIV - 8'h01);
    assign dataWr = cmdWrite && (cmdAddr == `ACD_CMD_DATA);

    always_comb begin
        s_d = s_q;
        s_d.sdaSync = {s_q.sdaSync[0], bus.sda};
        s_d.div = tick ? 8'h00 : s_q.div + 8'h01;
        s_d.rd = 8'h00;
        if (cmdWrite) begin
            case (cmdAddr)
                `ACD_CMD_ADDR_MAST: s_d.addrByte = cmdWrData;
                `ACD_CMD_DATA: begin
                    s_d.dataByte = cmdWrData;
                    s_d.haveData = 1'b1;
                end
                `ACD_CMD_CTRL: begin
                    s_d.stopAfter = cmdWrData[1];
                    s_d.ignoreAck = cmdWrData[2];
                    if (cmdWrData[0] && !s_q.busy) begin
                        s_d.busy  = 1'b1;
                        s_d.nack  = 1'b0;
                        s_d.state = ACD_M_START;
                    end
                end
                default: begin
                end
            endcase
        end
        if (cmdRead) begin
            case (cmdAddr)
                `ACD_CMD_ADDR_MAST: s_d.rd = s_q.addrByte;
                `ACD_CMD_DATA:      s_d.rd = s_q.dataByte;
                `ACD_CMD_STATUS:
                    s_d.rd = {5'h00, s_q.haveData, s_q.nack, s_q.busy};
                default:            s_d.rd = 8'h00;
            endcase
        end
        if (tick) begin
            s_d.phase = !s_q.phase;
            case (s_q.state)
                ACD_M_IDLE: begin
                    s_d.sclDrv = 1'b1;
                    s_d.sdaDrv = 1'b1;
                end
                ACD_M_START: begin
                    if (!s_q.phase) begin
                        s_d.sclDrv = 1'b1;
                        s_d.sdaDrv = 1'b1;
                    end else begin
                        s_d.sdaDrv = 1'b0;
                        s_d.shift  = s_q.addrByte;
                        s_d.bitCnt = 4'h0;
                        s_d.state  = ACD_M_BIT;
                    end
                end
                ACD_M_BIT: begin
                    // change data only with clock low
                    if (s_q.phase) begin
                        s_d.sclDrv = 1'b0;
                    end else if (!s_q.sclDrv) begin
                        s_d.sclDrv = 1'b1;
                    end
                    if (s_q.phase && s_q.bitCnt != `ACD_BYTE_BITS) begin
                        s_d.sdaDrv = s_q.shift[7];
                    end
                    if (!s_q.phase && !s_q.sclDrv) begin
                        s_d.shift  = {s_q.shift[6:0], 1'b0};
                        s_d.bitCnt = s_q.bitCnt + 4'h1;
                    end
                    if (s_q.phase && s_q.bitCnt == `ACD_BYTE_BITS) begin
                        s_d.sdaDrv = 1'b1;
                        s_d.state  = ACD_M_ACK;
                    end
                end
                ACD_M_ACK: begin
                    if (!s_q.phase) begin
                        s_d.sclDrv = 1'b1;
                    end else begin
                        s_d.sclDrv = 1'b0;
                        if (s_q.sdaSync[1] && !s_q.ignoreAck) begin
                            s_d.nack  = 1'b1;
                            s_d.state = ACD_M_STOP;
                        end else if (s_q.haveData) begin
                            s_d.shift    = s_q.dataByte;
                            // first bit goes out under this clock fall
                            s_d.sdaDrv   = s_q.dataByte[7];
                            // a byte written this cycle stays queued
                            s_d.haveData = dataWr;
                            s_d.bitCnt   = 4'h0;
                            s_d.state    = ACD_M_BIT;
                        end else if (s_q.stopAfter) begin
                            s_d.state = ACD_M_STOP;
                        end else begin
                            s_d.state = ACD_M_DONE;
                        end
                    end
                end
                ACD_M_DONE: begin
                    // hold clock low until more data or stop wanted
                    if (s_q.phase && s_q.haveData) begin
                        s_d.shift    = s_q.dataByte;
                        s_d.sdaDrv   = s_q.dataByte[7];
                        s_d.haveData = dataWr;
                        s_d.bitCnt   = 4'h0;
                        s_d.state    = ACD_M_BIT;
                    end else if (s_q.phase && s_q.stopAfter) begin
                        s_d.state = ACD_M_STOP;
                    end
                end
                ACD_M_STOP: begin
                    // data low under low clock, rises high
                    if (!s_q.sclDrv && s_q.sdaDrv) begin
                        s_d.sdaDrv = 1'b0;
                    end else if (!s_q.sclDrv) begin
                        s_d.sclDrv = 1'b1;
                    end else begin
                        s_d.sdaDrv = 1'b1;
                        s_d.busy   = 1'b0;
                        s_d.state  = ACD_M_IDLE;
                    end
                end
                default: begin
                    s_d.state = ACD_M_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.sclDrv  <= 1'b1;
            s_q.sdaDrv  <= 1'b1;
            s_q.sdaSync <= 2'h3;
            s_q.state   <= ACD_M_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // open drain: enable only when pulling low
    assign bus.sclOut    = 1'b0;
    assign bus.sclOe     = !s_q.sclDrv;
    assign bus.sdaMstOut = 1'b0;
    assign bus.sdaMstOe  = !s_q.sdaDrv;
    assign cmdRdData     = s_q.rd;
endmodule : acd_bus_master

// ==== acd_defs.svh ====
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH

`define ACD_CHIP_ADDR      8'h88
`define ACD_BYTE_BITS      4'h8
`define ACD_VOL_PFX_POS    7:6
`define ACD_VOL_PFX        2'h0
`define ACD_SPK_PFX_POS    7
`define ACD_SW_PFX_POS     7:5
`define ACD_SW_PFX         3'h2
`define ACD_TONE_PFX_POS   7:4
`define ACD_BASS_PFX       4'h6
`define ACD_TREB_PFX       4'h7
`define ACD_SPK_SEL_POS    6:5
`define ACD_SPK_LF         2'h0
`define ACD_SPK_RF         2'h1
`define ACD_SPK_LR         2'h2
`define ACD_SPK_RR         2'h3
`define ACD_MUTE_CODE      5'h1f
`define ACD_SETTING_RESET  8'h00
`define ACD_LINK_DIV       8'h08
`define ACD_CMD_ADDR_MAST  4'h0
`define ACD_CMD_DATA       4'h1
`define ACD_CMD_CTRL       4'h2
`define ACD_CMD_STATUS     4'h3

`endif

// ==== acd_pkg.sv ====
package acd_pkg;
    typedef enum logic [2:0] {
        ACD_S_IDLE = 3'h0,
        ACD_S_BITS = 3'h1,
        ACD_S_ACK  = 3'h3,
        ACD_S_SKIP = 3'h2
    } acd_slave_state_type;

    typedef enum logic [2:0] {
        ACD_M_IDLE  = 3'h0,
        ACD_M_START = 3'h1,
        ACD_M_BIT   = 3'h3,
        ACD_M_ACK   = 3'h2,
        ACD_M_STOP  = 3'h6,
        ACD_M_DONE  = 3'h7
    } acd_master_state_type;

    typedef struct packed {
        logic [7:0] volume;
        logic [7:0] attLf;
        logic [7:0] attRf;
        logic [7:0] attLr;
        logic [7:0] attRr;
        logic [7:0] switchSet;
        logic [7:0] lowTone;
        logic [7:0] highTone;
    } acd_settings_type;
endpackage : acd_pkg

// ==== acd_testbench.sv ====
`timescale 1ns/10ps
`include "acd_defs.svh"
module testbench;
    logic       clk;
    logic       srst;
    logic [3:0] cmdAddr;
    logic [7:0] cmdWrData;
    logic       cmdWrite;
    logic       cmdRead;
    logic [7:0] cmdRdData;
    logic [2:0] coarseVol;
    logic [2:0] fineVol;
    logic [4:0] att [4];
    logic [3:0] muteMask;
    logic [1:0] srcSel;
    logic       fourthSrc;
    logic       loudOff;
    logic [1:0] gain;
    logic [3:0] lowTone;
    logic [3:0] highTone;
    logic       strobe;
    logic [5:0] eVol;
    logic [4:0] eAtt [4];
    logic [4:0] eSw;
    logic [3:0] eLow;
    logic [3:0] eHigh;
    int         eApplied;
    int         applied;
    int         errorCnt;
    int         samplesChecked;

    acd_bus_if busIf ();
    acd_bus_master #(.HALF_DIV(8'h08)) i_acd_bus_master (
        .clk(clk), .srst(srst), .bus(busIf.master),
        .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .cmdWrite(cmdWrite),
        .cmdRead(cmdRead), .cmdRdData(cmdRdData));
    acd_audio_decoder i_acd_audio_decoder (
        .clk(clk), .srst(srst), .bus(busIf.device),
        .coarseStepVol_q(coarseVol), .fineStepVol_q(fineVol),
        .attLf_q(att[0]), .attRf_q(att[1]), .attLr_q(att[2]),
        .attRr_q(att[3]), .muteMask_q(muteMask),
        .sourceSelect_q(srcSel), .internalFourthSource_q(fourthSrc),
        .loudnessOff_q(loudOff), .inputGainField_q(gain),
        .lowTone_q(lowTone), .highTone_q(highTone),
        .settingStrobe_q(strobe));
    acd_bus_asserts i_acd_bus_asserts (
        .clk(clk), .srst(srst), .scl(busIf.scl), .sda(busIf.sda),
        .sdaMstOe(busIf.sdaMstOe), .sdaDevOe(busIf.sdaDevOe),
        .sdaDevOut(busIf.sdaDevOut));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (strobe === 1'b1) applied++;
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // idle cycle after each strobe keeps one driver per time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        cmdAddr   <= a;
        cmdWrData <= d;
        cmdWrite  <= 1'b1;
        @(posedge clk);
        cmdWrite <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        cmdAddr <= a;
        cmdRead <= 1'b1;
        @(posedge clk);
        cmdRead <= 1'b0;
        #1;
        d = cmdRdData;
        @(posedge clk);
    endtask : rd

    task automatic poll(input logic [7:0] m, input logic [7:0] v,
                        output logic [7:0] st);
        int n;
        n = 0;
        rd(`ACD_CMD_STATUS, st);
        while ((st & m) !== v && n < 500) begin
            rd(`ACD_CMD_STATUS, st);
            n++;
        end
        chk("status wait", v, st & m);
    endtask : poll

    task automatic model(input logic [7:0] b);
        if (b[7:6] == 2'b00) eVol = b[5:0];
        else if (b[7]) eAtt[b[6:5]] = b[4:0];
        else if (b[7:5] == 3'b010) eSw = b[4:0];
        else if (b[4]) eHigh = b[3:0];
        else eLow = b[3:0];
        eApplied++;
    endtask : model

    task automatic checkAll();
        logic [3:0] eMute;
        for (int i = 0; i < 4; i++) begin
            eMute[i] = eAtt[i] == `ACD_MUTE_CODE;
            chk("attenuator", {3'h0, eAtt[i]}, {3'h0, att[i]});
        end
        chk("mute", {4'h0, eMute}, {4'h0, muteMask});
        chk("volume", {2'h0, eVol}, {2'h0, coarseVol, fineVol});
        chk("switch", {3'h0, eSw}, {3'h0, gain, loudOff, srcSel});
        chk("fourth", {7'h0, &eSw[1:0]}, {7'h0, fourthSrc});
        chk("bass", {4'h0, eLow}, {4'h0, lowTone});
        chk("treble", {4'h0, eHigh}, {4'h0, highTone});
        chk("applied", eApplied[7:0], applied[7:0]);
    endtask : checkAll

    task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                        input logic [2:0] c);
        logic [7:0] st;
        wr(`ACD_CMD_ADDR_MAST, a);
        wr(`ACD_CMD_DATA, d);
        wr(`ACD_CMD_CTRL, {5'h0, c});
        poll(8'h01, 8'h00, st);
        if (a == `ACD_CHIP_ADDR) model(d);
        checkAll();
        // nack status only means something when the ack is watched
        if (!c[2]) chk("nack", {7'h0, a != `ACD_CHIP_ADDR},
                       {7'h0, st[1]});
    endtask : xfer

    task automatic testVolume();
        xfer(`ACD_CHIP_ADDR, 8'h24, 3'h3);
        xfer(`ACD_CHIP_ADDR, 8'h3f, 3'h3);
        xfer(`ACD_CHIP_ADDR, 8'h07, 3'h3);
    endtask : testVolume

    task automatic testSpeakers();
        for (int i = 0; i < 4; i++) begin
            xfer(`ACD_CHIP_ADDR, {1'b1, i[1:0], 5'h14}, 3'h3);
            xfer(`ACD_CHIP_ADDR, {1'b1, i[1:0], 5'h1f}, 3'h3);
        end
        xfer(`ACD_CHIP_ADDR, 8'h9e, 3'h3);
    endtask : testSpeakers

    task automatic testSwitch();
        for (int s = 0; s < 4; s++) begin
            xfer(`ACD_CHIP_ADDR, {3'b010, s[1:0], s[0], s[1:0]},
                 3'h3);
        end
    endtask : testSwitch

    task automatic testTones();
        xfer(`ACD_CHIP_ADDR, 8'h62, 3'h3);
        xfer(`ACD_CHIP_ADDR, 8'h78, 3'h3);
        xfer(`ACD_CHIP_ADDR, 8'h6f, 3'h3);
        xfer(`ACD_CHIP_ADDR, 8'h70, 3'h3);
    endtask : testTones

    task automatic testBadAddr();
        xfer(8'h89, 8'h00, 3'h3);
        xfer(8'h08, 8'h11, 3'h3);
        xfer(8'h98, 8'h22, 3'h3);
        xfer(8'h89, 8'h5c, 3'h7);
        xfer(`ACD_CHIP_ADDR, 8'h5c, 3'h7);
    endtask : testBadAddr

    // second byte queued while the first is still shifting out
    task automatic testMulti();
        logic [7:0] st;
        wr(`ACD_CMD_ADDR_MAST, `ACD_CHIP_ADDR);
        wr(`ACD_CMD_DATA, 8'h15);
        wr(`ACD_CMD_CTRL, 8'h01);
        poll(8'h04, 8'h00, st);
        wr(`ACD_CMD_DATA, 8'hd9);
        rd(`ACD_CMD_DATA, st);
        chk("data readback", 8'hd9, st);
        rd(`ACD_CMD_ADDR_MAST, st);
        chk("addr readback", `ACD_CHIP_ADDR, st);
        poll(8'h04, 8'h00, st);
        wr(`ACD_CMD_CTRL, 8'h02);
        poll(8'h01, 8'h00, st);
        model(8'h15);
        model(8'hd9);
        checkAll();
    endtask : testMulti

    task automatic closeOut();
        $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : closeOut

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        cmdAddr = 4'h0;
        cmdWrData = 8'h00;
        cmdWrite = 1'b0;
        cmdRead = 1'b0;
        eVol = 6'h00;
        eAtt = '{default: 5'h00};
        eSw = 5'h00;
        eLow = 4'h0;
        eHigh = 4'h0;
        eApplied = 0;
        applied = 0;
        errorCnt = 0;
        samplesChecked = 0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        checkAll();
        testVolume();
        testSpeakers();
        testSwitch();
        testTones();
        testBadAddr();
        testMulti();
        closeOut();
    end

    // about 25 frames of some 350 cycles each, so ample margin
    initial begin
        repeat (40000) @(posedge clk);
        errorCnt++;
        closeOut();
    end
endmodule : testbench
